/* File: core/dio_pkg.sv */
package dio_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;  // Core clock rate
  localparam int DOUT_PERIOD_MS = 1;           // Relay refresh time
  localparam int AIO_PERIOD_MS  = 4;           // Analog cycle time
  localparam int DOUT_CYCLES   = CLK_HZ / 1000 * DOUT_PERIOD_MS;
  localparam int AIO_CYCLES    = CLK_HZ / 1000 * AIO_PERIOD_MS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DOUT_SEL  = 8'h00; // Output state select
  localparam logic [7:0] OFS_AIN_CFG   = 8'h04; // Input config, filter
  localparam logic [7:0] OFS_AIN_GAIN  = 8'h08; // Input gain, Q8
  localparam logic [7:0] OFS_AIN_DZ    = 8'h0c; // Input dead zone
  localparam logic [7:0] OFS_AIN_WBD   = 8'h10; // Wire break delay
  localparam logic [7:0] OFS_AIN_STAT  = 8'h14; // Input status word
  localparam logic [7:0] OFS_AOUT_CFG  = 8'h18; // Source, abs, filter
  localparam logic [7:0] OFS_AOUT_GAIN = 8'h1c; // Output gain, Q8
  localparam logic [7:0] OFS_AOUT_DZ   = 8'h20; // Output dead zone
  localparam logic [7:0] OFS_AOUT_STAT = 8'h24; // Output status word
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h28; // Sticky events, RO
  localparam logic [7:0] OFS_IRQ_EN    = 8'h2c; // Event enables
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h30; // Write one clears
  localparam logic [7:0] OFS_OFF_FREQ  = 8'h34; // Off freq threshold
  localparam logic [7:0] OFS_MIN_FREQ  = 8'h38; // Minimum frequency
  localparam logic [7:0] OFS_CUR_THR   = 8'h3c; // Current threshold

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_BIPOLAR   = 0;   // Input config: bipolar input
  localparam int CFG_WB_EN     = 1;   // Input config: wire break on
  localparam int CFG_FILT_LSB  = 4;   // Filter shift, 3 bits
  localparam int AOUT_ABS_BIT  = 16;  // Output absolute value mode
  localparam int AOUT_FILT_LSB = 20;  // Output filter shift, 3 bits
  localparam int IRQ_WB        = 0;   // Wire break raised
  localparam int IRQ_NEG       = 1;   // Output source went negative in absolute mode
  localparam int IRQ_AIN       = 2;   // New input sample processed
  localparam int IRQ_BITS      = 3;

  // ----------------------------------------------------------------
  // Parameter numbers and reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] SW1_PARAM     = 12'h034;  // Status word one
  localparam logic [11:0] SW2_PARAM     = 12'h035;  // Status word two
  localparam logic [15:0] SRC_FREQ      = 16'h0015; // Smoothed freq
  localparam logic [15:0] SRC_CURRENT   = 16'h001b; // Output current
  localparam logic [15:0] SRC_AIN       = 16'h02f3; // Analog input
  localparam logic [15:0] DOUT_SEL_RST  = 16'h0343; // Fault active
  localparam logic [15:0] GAIN_RST      = 16'h0100; // Unity gain
  localparam logic [9:0]  DAC_MAX       = 10'h3ff;  // Full scale
  localparam logic [15:0] BIPOLAR_MID   = 16'h0200; // Bipolar zero

endpackage

/* File: core/dio_top.sv */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps

module dio_top #(
  parameter int DOUT_TICKS = dio_pkg::DOUT_CYCLES, // 1 ms in cycles
  parameter int AIO_TICKS  = dio_pkg::AIO_CYCLES   // 4 ms in cycles
) (
  input  wire logic        CLOCK_I,
  input  wire logic        RESETN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic [15:0] STATUS_WORD1_I,
  input  wire logic        DC_BRAKE_I,
  input  wire logic [15:0] FREQ_I,
  input  wire logic [15:0] SETPOINT_I,
  input  wire logic [15:0] CURRENT_I,
  input  wire logic [9:0]  ADC_DATA_I,
  output logic             RELAY_O,
  output logic      [9:0]  DAC_DATA_O,
  output logic             DAC_LOAD_O,
  output logic             WIRE_BREAK_FAULT_O,
  output logic             IRQ_O
);
  import dio_pkg::*;
  // ----------------------------------------------------------------
  // Shared arithmetic
  // ----------------------------------------------------------------
  // First-order lag: y += (x - y) / 2^sh; larger sh smooths more
  function automatic logic [15:0] lag(input logic [15:0] y,
                                      input logic [15:0] x,
                                      input logic [2:0]  sh);
    logic signed [16:0] d;
    d = (17'($signed(x)) - 17'($signed(y))) >>> sh;
    lag = 16'($signed(y) + d);
  endfunction
  // Gain in Q8, then values inside the dead zone read as zero
  function automatic logic [15:0] scale(input logic [15:0] x,
                                        input logic [15:0] g,
                                        input logic [9:0]  dz);
    logic signed [31:0] p;
    logic        [15:0] v;
    logic        [15:0] m;
    p = $signed(x) * $signed(g);
    v = p[23:8];
    m = v[15] ? 16'(-v) : v;
    scale = (m <= {6'h00, dz}) ? 16'h0000 : v;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] dout_cnt, next_dout_cnt;   // 1 ms divider
  logic [31:0] aio_cnt,  next_aio_cnt;    // 4 ms divider
  logic        tick_1ms, tick_4ms;        // Period strobes
  logic [9:0]  adc_meta, adc_sync;        // Pin synchroniser
  logic [15:0] dout_sel, next_dout_sel;   // output_state_select
  logic [7:0]  input_config, next_input_config;
  logic [15:0] ain_gain, next_ain_gain, aout_gain, next_aout_gain; // Q8
  logic [9:0]  dead_zone_width, next_dead_zone_width, aout_dz, next_aout_dz;
  logic [15:0] wire_break_delay, next_wire_break_delay;
  logic [31:0] aout_cfg, next_aout_cfg;   // Source, abs, filter
  logic [15:0] off_freq_threshold, next_off_freq_threshold;
  logic [15:0] min_freq, next_min_freq;
  logic [15:0] current_threshold, next_current_threshold;
  logic [IRQ_BITS-1:0] irq_en, next_irq_en;
  logic [IRQ_BITS-1:0] irq_stat, next_irq_stat;
  logic [31:0] prdata, next_prdata;
  logic        pready, next_pready, pslverr, next_pslverr;
  logic        relay, next_relay, wire_break, next_wire_break;
  logic [15:0] ain_filt, next_ain_filt, aout_filt, next_aout_filt; // Lags
  logic [15:0] ain_value, next_ain_value; // Processed input
  logic [15:0] wb_cnt, next_wb_cnt;       // Wire break timer
  logic [9:0]  dac, next_dac;
  logic        dac_load, next_dac_load, irq, next_irq;
  logic        aout_neg, next_aout_neg;   // output_status_word bit
  logic [15:0] status_word2;              // Comparator word
  logic        wb_ev, neg_ev, ain_ev;     // Event pulses
  logic        wr_acc;                    // Write completes this edge
  // ----------------------------------------------------------------
  // Cycle dividers
  // ----------------------------------------------------------------
  // Free-running counters; strobes last one clock
  always_comb begin
    tick_1ms      = (dout_cnt == 32'(DOUT_TICKS - 1));
    tick_4ms      = (aio_cnt == 32'(AIO_TICKS - 1));
    next_dout_cnt = tick_1ms ? 32'h0000_0000 : dout_cnt + 32'h1;
    next_aio_cnt  = tick_4ms ? 32'h0000_0000 : aio_cnt + 32'h1;
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dout_cnt <= 32'h0000_0000;
      aio_cnt  <= 32'h0000_0000;
    end else begin
      dout_cnt <= next_dout_cnt;
      aio_cnt  <= next_aio_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Converter input synchroniser
  // ----------------------------------------------------------------
  // Converter bits arrive from pins; meta stage feeds only sync stage
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      adc_meta <= 10'h000;
      adc_sync <= 10'h000;
    end else begin
      adc_meta <= ADC_DATA_I;
      adc_sync <= adc_meta;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and register file
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  always_comb begin
    next_dout_sel           = dout_sel;
    next_input_config       = input_config;
    next_ain_gain           = ain_gain;
    next_dead_zone_width    = dead_zone_width;
    next_wire_break_delay   = wire_break_delay;
    next_aout_cfg           = aout_cfg;
    next_aout_gain          = aout_gain;
    next_aout_dz            = aout_dz;
    next_off_freq_threshold = off_freq_threshold;
    next_min_freq           = min_freq;
    next_current_threshold  = current_threshold;
    next_irq_en             = irq_en;
    next_prdata             = prdata;
    next_pslverr            = 1'b0;
    next_pready             = PSEL_I && PENABLE_I && !pready;
    wr_acc                  = PSEL_I && PENABLE_I && pready && PWRITE_I;
    // Read data and error are settled in the same cycle as pready
    if (next_pready) begin
      next_prdata = 32'h0000_0000;
      case (PADDR_I)
        OFS_DOUT_SEL:  next_prdata = {16'h0000, dout_sel};
        OFS_AIN_CFG:   next_prdata = {24'h000000, input_config};
        OFS_AIN_GAIN:  next_prdata = {16'h0000, ain_gain};
        OFS_AIN_DZ:    next_prdata = {22'h000000, dead_zone_width};
        OFS_AIN_WBD:   next_prdata = {16'h0000, wire_break_delay};
        OFS_AIN_STAT:  next_prdata = {15'h0000, wire_break, ain_value};
        OFS_AOUT_CFG:  next_prdata = aout_cfg;
        OFS_AOUT_GAIN: next_prdata = {16'h0000, aout_gain};
        OFS_AOUT_DZ:   next_prdata = {22'h000000, aout_dz};
        OFS_AOUT_STAT: next_prdata = {6'h00, dac, 15'h0000, aout_neg};
        OFS_IRQ_STAT:  next_prdata = {29'h0, irq_stat};
        OFS_IRQ_EN:    next_prdata = {29'h0, irq_en};
        OFS_IRQ_CLR:   next_prdata = 32'h0000_0000; // Write-only
        OFS_OFF_FREQ:  next_prdata = {16'h0000, off_freq_threshold};
        OFS_MIN_FREQ:  next_prdata = {16'h0000, min_freq};
        OFS_CUR_THR:   next_prdata = {16'h0000, current_threshold};
        default:       next_pslverr = 1'b1;     // Unmapped address
      endcase
    end
    // Writes land on the edge that completes the transfer
    if (wr_acc) begin
      case (PADDR_I)
        OFS_DOUT_SEL:  next_dout_sel = PWDATA_I[15:0];
        OFS_AIN_CFG:   next_input_config = PWDATA_I[7:0];
        OFS_AIN_GAIN:  next_ain_gain = PWDATA_I[15:0];
        OFS_AIN_DZ:    next_dead_zone_width = PWDATA_I[9:0];
        OFS_AIN_WBD:   next_wire_break_delay = PWDATA_I[15:0];
        OFS_AOUT_CFG:  next_aout_cfg = PWDATA_I;
        OFS_AOUT_GAIN: next_aout_gain = PWDATA_I[15:0];
        OFS_AOUT_DZ:   next_aout_dz = PWDATA_I[9:0];
        OFS_IRQ_EN:    next_irq_en = PWDATA_I[IRQ_BITS-1:0];
        OFS_OFF_FREQ:  next_off_freq_threshold = PWDATA_I[15:0];
        OFS_MIN_FREQ:  next_min_freq = PWDATA_I[15:0];
        OFS_CUR_THR:   next_current_threshold = PWDATA_I[15:0];
        default:       next_irq_en = irq_en;        // RO or clear
      endcase
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dout_sel           <= DOUT_SEL_RST;
      input_config       <= 8'h00;
      ain_gain           <= GAIN_RST;
      dead_zone_width    <= 10'h000;
      wire_break_delay   <= 16'h0000;
      aout_cfg           <= {16'h0000, SRC_FREQ};
      aout_gain          <= GAIN_RST;
      aout_dz            <= 10'h000;
      off_freq_threshold <= 16'h0000;
      min_freq           <= 16'h0000;
      current_threshold  <= 16'h0000;
      irq_en             <= 3'h0;
      prdata             <= 32'h0000_0000;
      pready             <= 1'b0;
      pslverr            <= 1'b0;
    end else begin
      dout_sel           <= next_dout_sel;
      input_config       <= next_input_config;
      ain_gain           <= next_ain_gain;
      dead_zone_width    <= next_dead_zone_width;
      wire_break_delay   <= next_wire_break_delay;
      aout_cfg           <= next_aout_cfg;
      aout_gain          <= next_aout_gain;
      aout_dz            <= next_aout_dz;
      off_freq_threshold <= next_off_freq_threshold;
      min_freq           <= next_min_freq;
      current_threshold  <= next_current_threshold;
      irq_en             <= next_irq_en;
      prdata             <= next_prdata;
      pready             <= next_pready;
      pslverr            <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Relay output
  // ----------------------------------------------------------------
  // Word one arrives ready-made: 0 ready .. 9 process_data control,
  // A max freq .. F inverter overload; word two is built here from
  // signed compares on frequency and current, plus the DC brake input
  always_comb begin
    status_word2    = 16'h0000;
    status_word2[0] = DC_BRAKE_I;
    status_word2[1] = $signed(FREQ_I) >= $signed(off_freq_threshold);
    status_word2[2] = $signed(FREQ_I) > $signed(min_freq);
    status_word2[3] = $signed(CURRENT_I) >= $signed(current_threshold);
    status_word2[6] = $signed(FREQ_I) >= $signed(SETPOINT_I);
    next_relay      = relay;
    // Only a 1 ms strobe moves the relay; unknown numbers drive low
    if (tick_1ms) begin
      case (dout_sel[15:4])
        SW1_PARAM: next_relay = STATUS_WORD1_I[dout_sel[3:0]];
        SW2_PARAM: next_relay = status_word2[dout_sel[3:0]];
        default:   next_relay = 1'b0;
      endcase
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      relay <= 1'b0;
    end else begin
      relay <= next_relay;
    end
  end

  // ----------------------------------------------------------------
  // Analog input channel
  // ----------------------------------------------------------------
  // Everything advances once per 4 ms sample
  always_comb begin
    logic [15:0] raw;
    logic        wb_arm;
    logic        low;
    raw = {6'h00, adc_sync} - (input_config[CFG_BIPOLAR] ? BIPOLAR_MID
                                                          : 16'h0000);
    // Monitor needs enable, a nonzero width and a unipolar input
    wb_arm = input_config[CFG_WB_EN] && (dead_zone_width != 10'h000)
             && !input_config[CFG_BIPOLAR];
    low    = ({adc_sync, 1'b0} <= {1'b0, dead_zone_width});
    next_ain_filt   = ain_filt;
    next_ain_value  = ain_value;
    next_wb_cnt     = wb_cnt;
    next_wire_break = wire_break;
    wb_ev           = 1'b0;
    ain_ev          = tick_4ms;
    if (tick_4ms) begin
      next_ain_filt  = lag(ain_filt, raw,
                           input_config[CFG_FILT_LSB +: 3]);
      next_ain_value = scale(next_ain_filt, ain_gain,
                             dead_zone_width);
      if (!wb_arm || !low) begin
        // A brief dip restarts the count; the fault clears on recovery
        next_wb_cnt     = 16'h0000;
        next_wire_break = 1'b0;
      end else if (wb_cnt >= wire_break_delay) begin
        next_wire_break = 1'b1;
        wb_ev           = !wire_break;
      end else begin
        next_wb_cnt = wb_cnt + 16'h1;
      end
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      ain_filt   <= 16'h0000;
      ain_value  <= 16'h0000;
      wb_cnt     <= 16'h0000;
      wire_break <= 1'b0;
    end else begin
      ain_filt   <= next_ain_filt;
      ain_value  <= next_ain_value;
      wb_cnt     <= next_wb_cnt;
      wire_break <= next_wire_break;
    end
  end

  // ----------------------------------------------------------------
  // Analog output channel
  // ----------------------------------------------------------------
  // Negative results clamp to zero; the converter is unipolar
  always_comb begin
    logic [15:0] src;
    logic [15:0] mag;
    logic [15:0] scaled;
    src = 16'h0000;
    case (aout_cfg[15:0])
      SRC_FREQ:    src = FREQ_I;
      SRC_CURRENT: src = CURRENT_I;
      SRC_AIN:     src = ain_value;
      default:     src = 16'h0000;
    endcase
    // Absolute mode mirrors a negative source before the lag
    mag = (aout_cfg[AOUT_ABS_BIT] && src[15]) ? 16'(-src) : src;
    next_aout_filt = aout_filt;
    next_dac       = dac;
    next_aout_neg  = aout_neg;
    next_dac_load  = tick_4ms;
    neg_ev         = 1'b0;
    scaled         = scale(aout_filt, aout_gain, aout_dz);
    if (tick_4ms) begin
      next_aout_filt = lag(aout_filt, mag,
                           aout_cfg[AOUT_FILT_LSB +: 3]);
      scaled = scale(next_aout_filt, aout_gain, aout_dz);
      next_dac = scaled[15] ? 10'h000
               : (scaled > {6'h00, DAC_MAX}) ? DAC_MAX : scaled[9:0];
      next_aout_neg = aout_cfg[AOUT_ABS_BIT] && src[15];
      neg_ev        = next_aout_neg && !aout_neg;
    end
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      aout_filt <= 16'h0000;
      dac       <= 10'h000;
      dac_load  <= 1'b0;
      aout_neg  <= 1'b0;
    end else begin
      aout_filt <= next_aout_filt;
      dac       <= next_dac;
      dac_load  <= next_dac_load;
      aout_neg  <= next_aout_neg;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Set wins over a clear written in the same cycle
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_acc && PADDR_I == OFS_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~PWDATA_I[IRQ_BITS-1:0];
    end
    next_irq_stat[IRQ_WB]  = next_irq_stat[IRQ_WB] | wb_ev;
    next_irq_stat[IRQ_NEG] = next_irq_stat[IRQ_NEG] | neg_ev;
    next_irq_stat[IRQ_AIN] = next_irq_stat[IRQ_AIN] | ain_ev;
    next_irq = |(next_irq_stat & next_irq_en);
  end
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      irq_stat <= 3'h0;
      irq      <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
      irq      <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign PRDATA_O           = prdata;
  assign PREADY_O           = pready;
  assign PSLVERR_O          = pslverr;
  assign RELAY_O            = relay;
  assign DAC_DATA_O         = dac;
  assign DAC_LOAD_O         = dac_load;
  assign WIRE_BREAK_FAULT_O = wire_break;
  assign IRQ_O              = irq;
endmodule

/* File: verification/dio_field_model.sv */
`timescale 1ns/10ps
// Field transmitter on the analog input: steps at once or slews slowly
module dio_field_model (
  input  wire logic       clock_i,
  input  wire logic [9:0] target_i,  // Level the sensor heads for
  input  wire logic       slow_i,    // Slew one code per cycle
  output logic      [9:0] code_o     // Code at the converter pins
);
  initial code_o = 10'h000;
  always @(posedge clock_i) begin
    if (!slow_i || code_o == target_i) code_o <= target_i;
    else if (code_o < target_i) code_o <= code_o + 10'h001;
    else code_o <= code_o - 10'h001;
  end
endmodule

/* File: verification/dio_asserts.sv */
`timescale 1ns/10ps
module dio_chk #(
  parameter int DOUT_TICKS = 10,
  parameter int AIO_TICKS  = 40
) (
  input wire logic       CLOCK_I,
  input wire logic       RESETN_I,
  input wire logic       RELAY_O,
  input wire logic [9:0] DAC_DATA_O,
  input wire logic       DAC_LOAD_O,
  input wire logic       WIRE_BREAK_FAULT_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // Cycles since last load / relay change; negative until the first one
  int dgap, rgap;
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      dgap <= -1000000;
      rgap <= -1000000;
    end else begin
      dgap <= DAC_LOAD_O ? 0 : dgap + 1;
      rgap <= $changed(RELAY_O) ? 0 : rgap + 1;
    end
  end
  property p_dac_per; DAC_LOAD_O && dgap >= 0 |-> (dgap+1) % AIO_TICKS == 0;
  endproperty
  a_dac_per: assert property (p_dac_per) else $error("dac period");
  property p_dac_load; $changed(DAC_DATA_O) |-> DAC_LOAD_O; endproperty
  a_dac_load: assert property (p_dac_load) else $error("dac no load");
  property p_load_one; DAC_LOAD_O |=> !DAC_LOAD_O; endproperty
  a_load_one: assert property (p_load_one) else $error("load width");
  property p_dac_hold; DAC_LOAD_O |=> $stable(DAC_DATA_O) [*8]; endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac hold");
  property p_rly_per; $changed(RELAY_O) && rgap >= 0 |->
    (rgap + 1) % DOUT_TICKS == 0; endproperty
  a_rly_per: assert property (p_rly_per) else $error("relay period");
  property p_rly_hold; $changed(RELAY_O) |=> $stable(RELAY_O) [*8];
  endproperty
  a_rly_hold: assert property (p_rly_hold) else $error("relay hold");
  property p_wb_per; $changed(WIRE_BREAK_FAULT_O) && dgap >= 0 |->
    (dgap + 1) % AIO_TICKS == 0; endproperty
  a_wb_per: assert property (p_wb_per) else $error("fault period");
  property p_wb_hold;
    $changed(WIRE_BREAK_FAULT_O) |=> $stable(WIRE_BREAK_FAULT_O) [*8];
  endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("fault hold");
endmodule
bind dio_top dio_chk #(.DOUT_TICKS(DOUT_TICKS), .AIO_TICKS(AIO_TICKS))
  u_chk (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I), .RELAY_O(RELAY_O),
  .DAC_DATA_O(DAC_DATA_O), .DAC_LOAD_O(DAC_LOAD_O),
  .WIRE_BREAK_FAULT_O(WIRE_BREAK_FAULT_O));

/* File: verification/dio_tb.sv */
`timescale 1ns/10ps
`define CHK(n, x, s) begin n_tests++; if ((s) !== (x)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", n, x, s); end end
module drive_io_signal_channels_tb_top;
  import dio_pkg::*;
  localparam int DT = 10;  // Short 1 ms
  localparam int AT = 40;  // Short 4 ms
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, e, dcb = 0, slow = 0, relay, dload, wbf, irq;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, seed = 32'h66b7;
  logic [15:0] sw1 = 0, freq = 0, setp = 0, cur = 0, sel;
  logic [9:0]  tgt = 0, adc, dac;
  int          failures = 0, n_tests = 0;
  always #5 clk = ~clk;
  dio_field_model u_field (.clock_i(clk), .target_i(tgt), .slow_i(slow),
    .code_o(adc));
  dio_top #(.DOUT_TICKS(DT), .AIO_TICKS(AT)) u_dut (.CLOCK_I(clk),
    .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .STATUS_WORD1_I(sw1), .DC_BRAKE_I(dcb),
    .FREQ_I(freq), .SETPOINT_I(setp), .CURRENT_I(cur), .ADC_DATA_I(adc),
    .RELAY_O(relay), .DAC_DATA_O(dac), .DAC_LOAD_O(dload),
    .WIRE_BREAK_FAULT_O(wbf), .IRQ_O(irq));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Relay model; all word two thresholds are written as zero
  function automatic logic relay_exp();
    logic [15:0] w2;
    w2 = {9'h0, $signed(freq) >= $signed(setp), 2'b0, !cur[15],
          !freq[15] && freq != 0, !freq[15], dcb};
    if (sel[15:4] == SW1_PARAM) return sw1[sel[3:0]];
    if (sel[15:4] == SW2_PARAM) return w2[sel[3:0]];
    return 1'b0;
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 20) begin failures++; tally_and_finish(); end
  endtask
  task automatic rdchk(input string n, input logic [7:0] a,
                       input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(n, x, r)
  endtask
  task automatic tick(input int n); repeat (n) @(posedge clk); endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("sel_rst", OFS_DOUT_SEL, {16'h0, DOUT_SEL_RST});
    rdchk("unmapped", 8'h40, 32'h0);
    `CHK("slverr", 1'b1, e)
    for (int a = 'h34; a <= 'h3c; a += 4) apb(1'b1, 8'(a), 32'h0);
    for (int i = 0; i < 40; i++) begin
      sel = {i < 16 ? SW1_PARAM : i < 32 ? SW2_PARAM : 12'h0ff, 4'(i)};
      sw1 <= 16'(rnd());
      freq <= 16'(rnd());
      setp <= 16'(rnd());
      cur <= 16'(rnd());
      dcb <= 1'(rnd());
      apb(1'b1, OFS_DOUT_SEL, {16'h0, sel});
      tick(2 * DT);
      `CHK("relay", relay_exp(), relay)
    end
    apb(1'b1, OFS_AIN_DZ, 32'h0);
    apb(1'b1, OFS_AIN_GAIN, 32'h80);
    apb(1'b1, OFS_AIN_CFG, 32'h10);
    tgt <= 10'd200;
    tick(15 * AT);
    // Truncating lag stops one code short: 199 at half gain is 99
    rdchk("ain_val", OFS_AIN_STAT, 32'd99);
    apb(1'b1, OFS_AOUT_DZ, 32'h0);
    apb(1'b1, OFS_AOUT_CFG, {16'h0, SRC_AIN});
    tick(3 * AT);
    `CHK("dac_ain", 10'd99, dac)
    freq <= 16'hff38;
    apb(1'b1, OFS_AOUT_CFG, {15'h0, 1'b1, SRC_FREQ});
    tick(3 * AT);
    `CHK("dac_abs", 10'd200, dac)
    rdchk("aout_neg", OFS_AOUT_STAT, {6'h0, 10'd200, 16'h1});
    apb(1'b1, OFS_AOUT_DZ, 32'd250);
    tick(3 * AT);
    `CHK("dac_dz", 10'd0, dac)
    apb(1'b1, OFS_AOUT_DZ, 32'h0);
    apb(1'b1, OFS_AOUT_GAIN, 32'h200);
    tick(3 * AT);
    `CHK("dac_gain", 10'd400, dac)
    // Current source at double gain overshoots and must clamp
    cur <= 16'd700;
    apb(1'b1, OFS_AOUT_CFG, {16'h0, SRC_CURRENT});
    tick(3 * AT);
    `CHK("dac_cur", DAC_MAX, dac)
    apb(1'b1, OFS_IRQ_CLR, 32'h7);
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    apb(1'b1, OFS_AIN_DZ, 32'd100);
    apb(1'b1, OFS_AIN_WBD, 32'd3);
    apb(1'b1, OFS_AIN_CFG, 32'h2);
    repeat (2) begin
      tgt <= 10'd40;
      tick(2 * AT);
      tgt <= 10'd600;
      tick(AT);
    end
    `CHK("wb_dip", 1'b0, irq)
    tgt <= 10'd40;
    tick(6 * AT);
    `CHK("wb_fault", 1'b1, wbf)
    `CHK("wb_irq", 1'b1, irq)
    apb(1'b1, OFS_IRQ_CLR, 32'h1);
    tick(2);
    `CHK("irq_clr", 1'b0, irq)
    slow <= 1'b1;
    tgt <= 10'd60;
    tick(3 * AT);
    `CHK("wb_up", 1'b0, wbf)
    tgt <= 10'd40;
    apb(1'b1, OFS_AIN_CFG, 32'h3);
    tick(6 * AT);
    `CHK("wb_bip", 1'b0, wbf)
    apb(1'b1, OFS_AIN_DZ, 32'h0);
    apb(1'b1, OFS_AIN_CFG, 32'h2);
    slow <= 1'b0;
    tgt <= 10'd0;  // Zero code reads low even against a zero width
    tick(6 * AT);
    `CHK("wb_dz0", 1'b0, wbf)
    tally_and_finish();
  end
endmodule
